//--- rtl/cbc_pkg.sv
// Purpose: Shared constants for the battery charge state controller
// Assumes: 250 MHz system clock, 32-bit classic Wishbone register bus
// Notes:   Register offsets are byte addresses of aligned words

package cbc_pkg;

   // ----------------------------------------------------------------
   // Controller states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CBC_RESET = 2'b00,
      CBC_WAKE  = 2'b01,
      CBC_HALT  = 2'b10,
      CBC_REG   = 2'b11
   } cbc_state_e;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ          = 250;
   localparam int CMD_TIMEOUT_US   = 1000;
   localparam int CMD_TIMEOUT_CYC  = CMD_TIMEOUT_US * CLK_MHZ;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  ADR_CTRL     = 8'h00;
   localparam logic [7:0]  ADR_STATUS   = 8'h04;
   localparam logic [7:0]  ADR_TARGET   = 8'h08;
   localparam int          CTRL_HOLD    = 0;
   localparam int          CTRL_RESTART = 1;
   localparam int          CTRL_ATTN_CLR = 2;
   localparam logic [31:0] RDATA_RST    = 32'h0000_0000;
   localparam logic [15:0] TARGET_RST   = 16'h0000;

   // ----------------------------------------------------------------
   // Decoded slave command codes and alarm field
   // ----------------------------------------------------------------
   localparam logic [1:0] CMD_VOLT  = 2'h1;
   localparam logic [1:0] CMD_CURR  = 2'h2;
   localparam logic [1:0] CMD_ALARM = 2'h3;
   localparam int         ALARM_HI  = 15;
   localparam int         ALARM_LO  = 12;

   // ----------------------------------------------------------------
   // Pin input vector positions
   // ----------------------------------------------------------------
   localparam int PIN_BAT  = 0;
   localparam int PIN_AC   = 1;
   localparam int PIN_UR   = 2;
   localparam int PIN_COLD = 3;
   localparam int PIN_HOT  = 4;
   localparam int PIN_N    = 5;
   localparam logic [4:0] PIN_RST = 5'h00;

endpackage

//--- rtl/cbc_charge_ctrl.sv
// Purpose: Charge state controller: reset, wake-up, halted and regulated charge
// Assumes: Commands arrive already decoded from the bus slave block
// Notes:   Registers over classic Wishbone, single-cycle ack

`timescale 1ns/1ns

module cbc_charge_ctrl
   import cbc_pkg::*;
#(
   parameter int TIMEOUT_CYC = CMD_TIMEOUT_CYC,
   parameter int CNT_W       = 24
) (
   input  wire logic        clk_i,                    // System clock
   input  wire logic        rst_i,                    // Synchronous reset
   input  wire logic        power_up_clear_i,         // Asynchronous power-up clear
   input  wire logic        battery_present_i,        // Battery detected pin
   input  wire logic        adapter_power_valid_i,    // Adapter power pin
   input  wire logic        thermistor_under_range_i, // Thermistor under-range pin
   input  wire logic        thermistor_cold_i,        // Thermistor cold pin
   input  wire logic        thermistor_hot_i,         // Thermistor hot pin
   input  wire logic        cmd_valid_i,              // Decoded command strobe
   input  wire logic [1:0]  cmd_code_i,               // Decoded command code
   input  wire logic [15:0] cmd_data_i,               // Decoded command word
   input  wire logic        wb_cyc_i,                 // Wishbone cycle
   input  wire logic        wb_stb_i,                 // Wishbone strobe
   input  wire logic        wb_we_i,                  // Wishbone write
   input  wire logic [7:0]  wb_adr_i,                 // Wishbone byte address
   input  wire logic [3:0]  wb_sel_i,                 // Wishbone byte select
   input  wire logic [31:0] wb_dat_i,                 // Wishbone write data
   output logic [31:0]      wb_dat_o,                 // Wishbone read data
   output logic             wb_ack_o,                 // Wishbone acknowledge
   output logic             charge_enable_out_o,      // Charger enable
   output logic             trickle_current_o,        // Wake-up current enable
   output logic             host_attention_n_o,       // Host attention, active low
   output logic [15:0]      volt_target_o,            // Commanded voltage, mV
   output logic [15:0]      curr_target_o,            // Commanded current, mA
   output logic [3:0]       state_flags_o             // One-hot: reg, halt, wake, reset
);

   // ----------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------
   typedef struct packed {
      cbc_state_e         state;
      logic               woke_ideal;
      logic [PIN_N-1:0]   s0;
      logic [PIN_N-1:0]   s1;
      logic [PIN_N-1:0]   s2;
      logic [PIN_N-1:0]   flt;
      logic [PIN_N-1:0]   flt_d;
      logic               hold;
      logic               attn;
      logic               attn_n;
      logic               got_v;
      logic               got_c;
      logic               pair_open;
      logic [CNT_W-1:0]   pair_tmr;
      logic [CNT_W-1:0]   timer;
      logic [15:0]        volt;
      logic [15:0]        curr;
      logic               chg_en;
      logic               trickle;
      logic [3:0]         onehot;
      logic               ack;
      logic [31:0]        rdat;
   } cbc_regs_s;

   localparam logic [CNT_W-1:0] TMO_LIM = CNT_W'(TIMEOUT_CYC - 1);

   localparam cbc_regs_s REGS_RST = '{
      state: CBC_RESET, woke_ideal: 1'b0, s0: PIN_RST, s1: PIN_RST, s2: PIN_RST,
      flt: PIN_RST, flt_d: PIN_RST, hold: 1'b0, attn: 1'b0, attn_n: 1'b1, got_v: 1'b0,
      got_c: 1'b0, pair_open: 1'b0, pair_tmr: '0, timer: '0, volt: TARGET_RST,
      curr: TARGET_RST, chg_en: 1'b0, trickle: 1'b0, onehot: 4'h1, ack: 1'b0,
      rdat: RDATA_RST
   };

   cbc_regs_s r_reg;
   cbc_regs_s r_next;

   // Saturating time-out counter step
   function automatic logic [CNT_W-1:0] tick(input logic [CNT_W-1:0] t);
      tick = (t >= TMO_LIM) ? t : t + 1'b1;
   endfunction

   function automatic logic [3:0] state_onehot(input cbc_state_e s);
      state_onehot = 4'h1 << s;
   endfunction

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   logic wr_ctrl;
   logic restart;
   logic pres_ok;
   logic pres_chg;
   logic ideal;
   logic ur_or_cold;
   logic hot_rise;
   logic ur_fall;
   logic cmd_v;
   logic cmd_c;
   logic pair_now;
   logic alarm_hit;
   logic tmo;
   logic therm_ok;

   always_comb begin
      r_next = r_reg;

      // Bus slave: ack one cycle after the request, then drop
      r_next.ack  = wb_cyc_i & wb_stb_i & ~r_reg.ack;
      wr_ctrl     = r_next.ack & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADR_CTRL);
      restart     = wr_ctrl & wb_dat_i[CTRL_RESTART];
      if (wr_ctrl) begin
         r_next.hold = wb_dat_i[CTRL_HOLD];
      end

      // Pin synchronisers: a change counts once stages two and three agree
      r_next.s0    = {thermistor_hot_i, thermistor_cold_i, thermistor_under_range_i,
                      adapter_power_valid_i, battery_present_i};
      r_next.s1    = r_reg.s0;
      r_next.s2    = r_reg.s1;
      r_next.flt   = (~(r_reg.s1 ^ r_reg.s2) & r_reg.s2) | ((r_reg.s1 ^ r_reg.s2) & r_reg.flt);
      r_next.flt_d = r_reg.flt;

      pres_ok    = r_reg.flt[PIN_BAT] & r_reg.flt[PIN_AC];
      pres_chg   = (r_reg.flt[PIN_BAT] ^ r_reg.flt_d[PIN_BAT])
                 | (r_reg.flt[PIN_AC] ^ r_reg.flt_d[PIN_AC]);
      ur_or_cold = r_reg.flt[PIN_UR] | r_reg.flt[PIN_COLD];
      ideal      = ~ur_or_cold & ~r_reg.flt[PIN_HOT];
      hot_rise   = r_reg.flt[PIN_HOT] & ~r_reg.flt_d[PIN_HOT];
      ur_fall    = ~r_reg.flt[PIN_UR] & r_reg.flt_d[PIN_UR];
      therm_ok   = ~r_reg.flt[PIN_HOT] | r_reg.flt[PIN_UR];

      // presence change; set wins over clear
      if (r_next.ack & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADR_CTRL)
          & wb_dat_i[CTRL_ATTN_CLR]) begin
         r_next.attn = 1'b0;
      end
      if (pres_chg) begin
         r_next.attn = 1'b1;
      end
      r_next.attn_n = ~r_next.attn;

      cmd_v     = cmd_valid_i & (cmd_code_i == CMD_VOLT);
      cmd_c     = cmd_valid_i & (cmd_code_i == CMD_CURR);
      alarm_hit = cmd_valid_i & (cmd_code_i == CMD_ALARM) & (|cmd_data_i[ALARM_HI:ALARM_LO]);
      if (cmd_v) begin
         r_next.volt  = cmd_data_i;
         r_next.got_v = 1'b1;
      end
      if (cmd_c) begin
         r_next.curr  = cmd_data_i;
         r_next.got_c = 1'b1;
      end
      pair_now = (cmd_v | cmd_c) & (r_next.got_v & r_next.got_c);

      // Pair window: both halves must land within one time-out
      if (r_reg.pair_open) begin
         r_next.pair_tmr = tick(r_reg.pair_tmr);
         if (r_reg.pair_tmr >= TMO_LIM) begin
            r_next.pair_open = 1'b0;
            r_next.got_v     = cmd_v;
            r_next.got_c     = cmd_c;
         end
      end
      if ((cmd_v | cmd_c) & ~r_reg.pair_open) begin
         r_next.pair_open = 1'b1;
         r_next.pair_tmr  = '0;
      end

      tmo          = (r_reg.timer >= TMO_LIM);
      r_next.timer = tick(r_reg.timer);
      if (pair_now) begin
         r_next.timer     = '0;
         r_next.got_v     = 1'b0;
         r_next.got_c     = 1'b0;
         r_next.pair_open = 1'b0;
      end

      if (~pres_ok | restart) begin
         r_next.state = CBC_RESET;
      end else begin
         unique case (r_reg.state)
            CBC_RESET: begin
               if (~r_reg.hold & ideal) begin
                  r_next.state      = CBC_WAKE;
                  r_next.woke_ideal = 1'b1;
               end else if (~r_reg.hold & ur_or_cold) begin
                  r_next.state      = CBC_WAKE;
                  r_next.woke_ideal = 1'b0;
               end
            end
            CBC_WAKE: begin
               if (alarm_hit) begin
                  r_next.state = CBC_HALT;
               end else if (tmo & ur_or_cold & ~pair_now) begin
                  r_next.state = CBC_HALT;
               end else if (r_reg.woke_ideal & hot_rise & ~r_reg.flt[PIN_UR]) begin
                  r_next.state = CBC_HALT;
               end else if (~r_reg.woke_ideal & ur_fall & r_reg.flt[PIN_HOT]) begin
                  r_next.state = CBC_HALT;
               end else if (pair_now & ~r_reg.hold & therm_ok) begin
                  r_next.state = CBC_REG;
               end
            end
            CBC_HALT: begin
               // only regulated or reset leave halt
               if (pair_now & ~r_reg.hold & therm_ok) begin
                  r_next.state = CBC_REG;
               end
            end
            CBC_REG: begin
               if (alarm_hit) begin
                  r_next.state = CBC_HALT;
               end else if (tmo & ~pair_now) begin
                  r_next.state = CBC_HALT;
               end else if ((hot_rise & ~r_reg.flt[PIN_UR])
                            | (ur_fall & r_reg.flt[PIN_HOT])) begin
                  r_next.state = CBC_HALT;
               end
            end
         endcase
      end

      if (r_next.state == CBC_RESET) begin
         r_next.timer = '0;
      end

      unique case (r_next.state)
         CBC_WAKE: r_next.chg_en = ~r_next.hold;
         CBC_REG:  r_next.chg_en = ~r_next.hold & (r_next.volt != TARGET_RST);
         default:  r_next.chg_en = 1'b0;
      endcase
      r_next.trickle = (r_next.state == CBC_WAKE) & ~r_next.hold;
      r_next.onehot  = state_onehot(r_next.state);

      // Read data registered with the ack
      r_next.rdat = RDATA_RST;
      if (r_next.ack & ~wb_we_i) begin
         unique case (wb_adr_i)
            ADR_CTRL:   r_next.rdat = {31'h0000_0000, r_reg.hold};
            ADR_STATUS: r_next.rdat = {21'h00_0000, r_reg.woke_ideal, r_reg.chg_en,
                                       r_reg.attn, r_reg.flt, 1'b0, r_reg.state};
            ADR_TARGET: r_next.rdat = {r_reg.curr, r_reg.volt};
            default:    r_next.rdat = RDATA_RST;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // asynchronous power-up clear
   always_ff @(posedge clk_i or posedge power_up_clear_i) begin
      if (power_up_clear_i) begin
         r_reg <= REGS_RST;
      end else if (rst_i) begin
         r_reg <= REGS_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign wb_dat_o            = r_reg.rdat;
   assign wb_ack_o            = r_reg.ack;
   assign charge_enable_out_o = r_reg.chg_en;
   assign trickle_current_o   = r_reg.trickle;
   assign host_attention_n_o  = r_reg.attn_n;
   assign volt_target_o       = r_reg.volt;
   assign curr_target_o       = r_reg.curr;
   assign state_flags_o       = r_reg.onehot;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || power_up_clear_i);

   sequence s_live;
      pres_ok && !restart;
   endsequence

   sequence s_alarm_in_run;
      s_live ##0 alarm_hit && (r_reg.state == CBC_WAKE || r_reg.state == CBC_REG);
   endsequence

   property p_onehot;
      $onehot(state_flags_o);
   endproperty
   a_onehot: assert property (p_onehot) else $error("state flags not one-hot");

   property p_attn;
      pres_chg |=> !host_attention_n_o;
   endproperty
   a_attn: assert property (p_attn) else $error("attention not raised");

   property p_restart;
      (!pres_ok || restart) |=> state_flags_o == 4'h1 ##0 !charge_enable_out_o;
   endproperty
   a_restart: assert property (p_restart) else $error("reset state not entered");

   property p_alarm;
      s_alarm_in_run |=> state_flags_o[CBC_HALT] && !charge_enable_out_o;
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm did not halt");

   property p_reg_tmo;
      s_live ##0 (r_reg.state == CBC_REG && tmo && !pair_now) |=> state_flags_o[CBC_HALT];
   endproperty
   a_reg_tmo: assert property (p_reg_tmo) else $error("regulated time-out missed");

   property p_no_retrickle;
      state_flags_o[CBC_HALT] |=> !state_flags_o[CBC_WAKE];
   endproperty
   a_no_retrickle: assert property (p_no_retrickle) else $error("trickle after halt");

   property p_enter_reg;
      s_live ##0 (r_reg.state == CBC_HALT && pair_now && !r_reg.hold
                  && (!r_reg.flt[PIN_HOT] || r_reg.flt[PIN_UR]))
         |=> state_flags_o[CBC_REG];
   endproperty
   a_enter_reg: assert property (p_enter_reg) else $error("pair did not regulate");

   property p_hold;
      r_reg.hold |-> !charge_enable_out_o && !trickle_current_o;
   endproperty
   a_hold: assert property (p_hold) else $error("charging under hold-off");

   property p_zero_volt;
      (state_flags_o[CBC_REG] && volt_target_o == TARGET_RST) |-> !charge_enable_out_o;
   endproperty
   a_zero_volt: assert property (p_zero_volt) else $error("zero volts still enabled");

   property p_timer_clr;
      state_flags_o[CBC_RESET] |-> r_reg.timer == '0;
   endproperty
   a_timer_clr: assert property (p_timer_clr) else $error("timer not cleared");

endmodule

//--- tb/cbc_cmd_src.sv
// Purpose: Issuer of decoded charge commands, battery or system host side
// Assumes: One command per request, one-cycle strobe
// Notes:   Idle code and data lines show the inverse of the last command
`timescale 1ns/1ns

module cbc_cmd_src (
   input  wire logic        clk_i,        // System clock
   output logic             cmd_valid_o,  // Command strobe
   output logic [1:0]       cmd_code_o,   // Command code
   output logic [15:0]      cmd_data_o    // Command word
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o  = 2'h0;
      cmd_data_o  = 16'h0000;
   end

   task automatic send(input logic [1:0] code, input logic [15:0] data);
      @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      cmd_code_o  <= code;
      cmd_data_o  <= data;
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
      cmd_code_o  <= ~code;
      cmd_data_o  <= ~data;
   endtask
endmodule

//--- tb/tb.sv
// Purpose: Self-checking bench for the charge state controller
// Assumes: Short command time-out of 20 cycles
// Notes:   Expected targets kept in a small model of the last commands
`timescale 1ns/1ns

module tb;
   import cbc_pkg::*;
   localparam int TO = 20;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        puc   = 1'b0;
   logic        bat   = 1'b0;
   logic        ac    = 1'b0;
   logic        ur    = 1'b0;
   logic        cold  = 1'b0;
   logic        hot   = 1'b0;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [3:0]  sel   = 4'h0;
   logic [31:0] wdat  = 32'h0000_0000;
   logic        cvld;
   logic [1:0]  ccode;
   logic [15:0] cdata;
   logic [31:0] rdat;
   logic        ack;
   logic        ce;
   logic        trk;
   logic        attn_n;
   logic [15:0] vt;
   logic [15:0] ct;
   logic [3:0]  sf;
   logic [15:0] v;
   logic [15:0] c;
   logic [31:0] rd;
   int          rst_cnt = 0;
   int          n_errors = 0;
   int          cmp_count = 0;
   int          i;

   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) if (sf === 4'b0001) rst_cnt <= rst_cnt + 1;

   cbc_cmd_src i_src (.clk_i(clk_i), .cmd_valid_o(cvld), .cmd_code_o(ccode), .cmd_data_o(cdata));

   cbc_charge_ctrl #(.TIMEOUT_CYC(TO), .CNT_W(24)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .power_up_clear_i(puc), .battery_present_i(bat),
      .adapter_power_valid_i(ac), .thermistor_under_range_i(ur), .thermistor_cold_i(cold),
      .thermistor_hot_i(hot), .cmd_valid_i(cvld), .cmd_code_i(ccode), .cmd_data_i(cdata),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .charge_enable_out_o(ce),
      .trickle_current_o(trk), .host_attention_n_o(attn_n), .volt_target_o(vt),
      .curr_target_o(ct), .state_flags_o(sf));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= 4'hf;
      wdat <= d;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      if (ack !== 1'b1) begin
         chk("wb_ack", 32'h0000_0001, 32'h0000_0000);
         complete_run();
      end
      rd = rdat;
      cyc  <= 1'b0;
      stb  <= 1'b0;
      we   <= 1'b0;
      wdat <= ~d;
      @(posedge clk_i);
   endtask

   task automatic pins(input logic b, input logic a, input logic u, input logic cd,
                       input logic h);
      @(posedge clk_i);
      bat  <= b;
      ac   <= a;
      ur   <= u;
      cold <= cd;
      hot  <= h;
   endtask

   task automatic wst(input logic [3:0] e);
      for (int k = 0; k < 40 && sf !== e; k++) tick(1);
      chk("state_flags", {28'h000_0000, e}, {28'h000_0000, sf});
      if (sf !== e) complete_run();
   endtask

   task automatic pair(input logic [15:0] pv, input logic [15:0] pc);
      i_src.send(CMD_VOLT, pv);
      i_src.send(CMD_CURR, pc);
      tick(2);
      v = pv;
      c = pc;
      chk("volt_target", {16'h0000, v}, {16'h0000, vt});
      chk("curr_target", {16'h0000, c}, {16'h0000, ct});
   endtask

   task automatic rpair();
      pair(16'($urandom() % 32'd65535) + 16'h0001, 16'($urandom()));
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(87927));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      tick(1);
      chk("state_flags", 32'h0000_0001, {28'h000_0000, sf});
      chk("charge_enable", 32'h0000_0000, {31'h0, ce});
      pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      wst(4'b0010);
      tick(2);
      chk("charge_enable", 32'h0000_0001, {31'h0, ce});
      chk("trickle", 32'h0000_0001, {31'h0, trk});
      chk("attention_n", 32'h0000_0000, {31'h0, attn_n});
      wb(1'b1, ADR_CTRL, 32'h0000_0004);
      tick(2);
      chk("attention_n", 32'h0000_0001, {31'h0, attn_n});
      tick(TO + 10);
      chk("state_flags", 32'h0000_0002, {28'h000_0000, sf});
      wb(1'b1, ADR_CTRL, 32'h0000_0001);
      tick(2);
      chk("charge_enable", 32'h0000_0000, {31'h0, ce});
      chk("state_flags", 32'h0000_0002, {28'h000_0000, sf});
      wb(1'b0, ADR_CTRL, 32'h0000_0000);
      chk("ctrl_reg", 32'h0000_0001, rd);
      wb(1'b0, 8'hfc, 32'h0000_0000);
      chk("unmapped_read", 32'h0000_0000, rd);
      wb(1'b1, ADR_CTRL, 32'h0000_0000);
      tick(2);
      chk("charge_enable", 32'h0000_0001, {31'h0, ce});
      rpair();
      wst(4'b1000);
      chk("charge_enable", 32'h0000_0001, {31'h0, ce});
      wb(1'b0, ADR_TARGET, 32'h0000_0000);
      chk("target_reg", {c, v}, rd);
      wb(1'b0, ADR_STATUS, 32'h0000_0000);
      chk("status_reg", 32'h0000_061b, rd);
      wb(1'b1, ADR_CTRL, 32'h0000_0001);
      tick(2);
      chk("charge_enable", 32'h0000_0000, {31'h0, ce});
      rpair();
      chk("state_flags", 32'h0000_0008, {28'h000_0000, sf});
      wb(1'b1, ADR_CTRL, 32'h0000_0000);
      tick(2);
      chk("charge_enable", 32'h0000_0001, {31'h0, ce});
      pair(16'h0000, 16'h0100);
      chk("charge_enable", 32'h0000_0000, {31'h0, ce});
      rpair();
      i_src.send(CMD_ALARM, 16'h0fff);
      tick(2);
      chk("state_flags", 32'h0000_0008, {28'h000_0000, sf});
      for (i = ALARM_LO; i <= ALARM_HI; i++) begin
         i_src.send(CMD_ALARM, 16'h0001 << i);
         wst(4'b0100);
         chk("trickle", 32'h0000_0000, {31'h0, trk});
         rpair();
         wst(4'b1000);
      end
      tick(TO - 8);
      rpair();
      tick(TO - 8);
      chk("state_flags", 32'h0000_0008, {28'h000_0000, sf});
      wst(4'b0100);
      i = rst_cnt;
      wb(1'b1, ADR_CTRL, 32'h0000_0002);
      wst(4'b0010);
      chk("seen_reset", 32'h0000_0001, {31'h0, rst_cnt > i});
      pins(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      wst(4'b0001);
      chk("attention_n", 32'h0000_0000, {31'h0, attn_n});
      pins(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
      wst(4'b0010);
      tick(TO - 12);
      chk("state_flags", 32'h0000_0002, {28'h000_0000, sf});
      wst(4'b0100);
      pins(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      wst(4'b0001);
      pins(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
      wst(4'b0010);
      pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
      wst(4'b0100);
      pins(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      wst(4'b0001);
      pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      wst(4'b0010);
      pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
      wst(4'b0100);
      rpair();
      tick(3);
      chk("state_flags", 32'h0000_0004, {28'h000_0000, sf});
      @(posedge clk_i);
      puc <= 1'b1;
      #1;
      chk("state_flags", 32'h0000_0001, {28'h000_0000, sf});
      chk("charge_enable", 32'h0000_0000, {31'h0, ce});
      tick(2);
      @(posedge clk_i);
      puc <= 1'b0;
      tick(2);
      chk("state_flags", 32'h0000_0001, {28'h000_0000, sf});
      chk("attention_n", 32'h0000_0001, {31'h0, attn_n});
      complete_run();
   end
endmodule
